// ### rtl/bapc_pkg.sv
// shared constants and carrier types for the bus access protection checker
package bapc_pkg;
    // access attribute widths
    localparam int ADDR_W = 32;
    localparam int MASTER_W = 3;
    localparam int PID_W = 8;
    localparam int NUM_MASTERS = 8;
    localparam int NUM_FULL_MASTERS = 4;

    // wishbone register map, byte addresses
    localparam int WB_ADR_W = 12;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] ERR_BASE = 12'h010;
    localparam int ERR_STRIDE = 8;
    localparam logic [11:0] DESC_BASE = 12'h400;
    localparam int DESC_STRIDE = 16;
    localparam logic [11:0] AAC_BASE = 12'h800;
    localparam int AAC_STRIDE = 4;

    // global control/status fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SLAVE_PORT_ERROR_FLAGS_LSB = 8;
    localparam logic CTRL_EN_RESET = 1'b0;

    // descriptor word 3 fields
    localparam int VALID_BIT = 31;
    localparam int PID_LSB = 8;
    localparam int MASK_LSB = 0;

    // descriptor word 2 fields: masters 0..3 have pe, sm[1:0], um{r,w,x}
    localparam int FIELD_W = 6;
    localparam int FIELD_PE_BIT = 5;
    localparam int FIELD_SM_LSB = 3;
    localparam int FIELD_UM_LSB = 0;
    // masters 4..7 have only a write enable and a read enable each
    localparam int RW_LSB = 24;
    localparam logic [31:0] ACCESS_RESET = 32'h0000_0000;

    // error detail capture fields
    localparam int EDR_ACD_LSB = 16;
    localparam int EDR_MASTER_LSB = 4;
    localparam int EDR_WRITE_BIT = 2;
    localparam int EDR_SUP_BIT = 1;
    localparam int EDR_DATA_BIT = 0;

    // ahb encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic HRESP_ERROR = 1'b1;
    localparam int HPROT_DATA_BIT = 0;
    localparam int HPROT_PRIV_BIT = 1;

    // supervisor access field encodings
    localparam logic [1:0] SM_RWX = 2'h0;
    localparam logic [1:0] SM_RX = 2'h1;
    localparam logic [1:0] SM_RW = 2'h2;
    localparam logic [1:0] SM_USER = 2'h3;

    typedef enum {GATE_PASS, GATE_ERR1, GATE_ERR2} bapc_gate_state_type;

    // address phase of one crossbar slave port
    typedef struct packed {
        logic [1:0] htrans;
        logic [ADDR_W-1:0] haddr;
        logic hwrite;
        logic [3:0] hprot;
        logic [MASTER_W-1:0] hmaster;
        logic [PID_W-1:0] pid;
    } bapc_ahb_req_type;

    // response of a slave, or toward a master
    typedef struct packed {
        logic hready;
        logic hresp;
    } bapc_ahb_rsp_type;

    // one region descriptor as seen by an evaluation macro
    typedef struct packed {
        logic [ADDR_W-1:0] start_addr;
        logic [ADDR_W-1:0] end_addr;
        logic [31:0] access;
        logic [PID_W-1:0] pid;
        logic [PID_W-1:0] process_identifier_mask;
        logic valid_flag;
    } bapc_desc_type;
endpackage : bapc_pkg

// ### rtl/bapc_eval.sv
// access evaluation macro: one region descriptor against one address phase
`timescale 1ns/100ps
module bapc_eval (
    input wire logic enable,
    input wire bapc_pkg::bapc_desc_type desc,
    input wire bapc_pkg::bapc_ahb_req_type req,
    output logic not_allowed,
    output logic err_term
);
    logic live;
    logic [bapc_pkg::ADDR_W-1:0] addr_iso;
    logic [bapc_pkg::PID_W-1:0] pid_iso;
    logic [2:0] eff_rwx;
    logic pid_en;
    logic pid_hit;
    logic range_hit;
    logic hit;
    logic violation;

    // inputs held at zero when idle keep the comparators quiet
    assign live = enable & desc.valid_flag;
    assign addr_iso = live ? req.haddr : '0;
    assign pid_iso = live ? req.pid : '0;

    // effective r, w, x for the requesting master
    always_comb begin
        int m;
        logic [bapc_pkg::FIELD_W-1:0] fld;
        m = int'(req.hmaster);
        fld = '0;
        eff_rwx = 3'h0;
        pid_en = 1'b0;
        if (m < bapc_pkg::NUM_FULL_MASTERS) begin
            fld = desc.access[m*bapc_pkg::FIELD_W +: bapc_pkg::FIELD_W];
            pid_en = fld[bapc_pkg::FIELD_PE_BIT];
            if (req.hprot[bapc_pkg::HPROT_PRIV_BIT]) begin
                case (fld[bapc_pkg::FIELD_SM_LSB +: 2])
                    bapc_pkg::SM_RWX: eff_rwx = 3'h7;
                    bapc_pkg::SM_RX: eff_rwx = 3'h5;
                    bapc_pkg::SM_RW: eff_rwx = 3'h6;
                    default: eff_rwx = fld[bapc_pkg::FIELD_UM_LSB +: 3];
                endcase
            end else begin
                eff_rwx = fld[bapc_pkg::FIELD_UM_LSB +: 3];
            end
        end else begin
            // read and write only, never execute
            eff_rwx[2] = desc.access[bapc_pkg::RW_LSB + 2*(m-4) + 1];
            eff_rwx[1] = desc.access[bapc_pkg::RW_LSB + 2*(m-4)];
        end
    end

    // masked identifier compare, forced true without identifier enable
    assign pid_hit = ~pid_en |
        ((pid_iso & desc.process_identifier_mask) ==
         (desc.pid & desc.process_identifier_mask));

    // inclusive range with no ordering check on the bounds
    assign range_hit = (addr_iso >= desc.start_addr) &
        (addr_iso <= desc.end_addr);
    assign hit = live & range_hit & pid_hit;

    // permission check, a set bit grants
    always_comb begin
        if (!live) begin
            violation = 1'b0;
        end else if (!req.hprot[bapc_pkg::HPROT_DATA_BIT]) begin
            violation = ~eff_rwx[0];
        end else if (req.hwrite) begin
            violation = ~eff_rwx[1];
        end else begin
            violation = ~eff_rwx[2];
        end
    end

    assign not_allowed = ~hit | violation;
    assign err_term = hit & violation;
endmodule : bapc_eval

// ### rtl/bapc_gate.sv
// per slave port gate: cancels denied transfers and forms the error response
`timescale 1ns/100ps
module bapc_gate (
    input wire logic clk,
    input wire logic rst,
    input wire logic deny,
    input wire bapc_pkg::bapc_ahb_req_type m_req,
    input wire bapc_pkg::bapc_ahb_rsp_type s_rsp,
    output bapc_pkg::bapc_ahb_req_type s_req,
    output logic s_hready,
    output bapc_pkg::bapc_ahb_rsp_type m_rsp,
    output logic fault
);
    bapc_pkg::bapc_gate_state_type state_reg;
    bapc_pkg::bapc_gate_state_type state_next;
    logic denied;

    assign denied = deny & m_req.htrans[1];

    // master side response
    always_comb begin
        case (state_reg)
            bapc_pkg::GATE_ERR1: begin
                m_rsp.hready = 1'b0;
                m_rsp.hresp = bapc_pkg::HRESP_ERROR;
            end
            bapc_pkg::GATE_ERR2: begin
                m_rsp.hready = 1'b1;
                m_rsp.hresp = bapc_pkg::HRESP_ERROR;
            end
            default: begin
                m_rsp = s_rsp;
            end
        endcase
    end

    assign s_hready = m_rsp.hready;
    assign fault = denied & m_rsp.hready;

    // slave sees the original signals unless cancelled
    always_comb begin
        s_req = m_req;
        if (denied || state_reg == bapc_pkg::GATE_ERR1) begin
            s_req.htrans = bapc_pkg::HTRANS_IDLE;
        end
    end

    // two-cycle error sequence after a denied address phase
    always_comb begin
        case (state_reg)
            bapc_pkg::GATE_PASS: state_next = fault ? bapc_pkg::GATE_ERR1 : bapc_pkg::GATE_PASS;
            bapc_pkg::GATE_ERR1: state_next = bapc_pkg::GATE_ERR2;
            bapc_pkg::GATE_ERR2: state_next = fault ? bapc_pkg::GATE_ERR1 : bapc_pkg::GATE_PASS;
            default: state_next = bapc_pkg::GATE_PASS;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= bapc_pkg::GATE_PASS;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule : bapc_gate

// ### rtl/bapc_top.sv
// bus access protection checker: register file, evaluation matrix, port gates
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/100ps
module bapc_top #(
    parameter int N_DESC = 8,
    parameter int N_PORT = 2,
    parameter logic [7:0] DMA_MASTERS = 8'h02
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire bapc_pkg::bapc_ahb_req_type M_REQ [N_PORT],
    output bapc_pkg::bapc_ahb_rsp_type M_RSP [N_PORT],
    output bapc_pkg::bapc_ahb_req_type S_REQ [N_PORT],
    output logic S_HREADY [N_PORT],
    input wire bapc_pkg::bapc_ahb_rsp_type S_RSP [N_PORT],
    output logic DMA_IRQ
);
    // bus slave state
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_strobe;
    logic rd_strobe;

    // global control and descriptor storage
    logic en_reg;
    logic en_next;
    logic [31:0] start_reg [N_DESC];
    logic [31:0] start_next [N_DESC];
    logic [31:0] end_reg [N_DESC];
    logic [31:0] end_next [N_DESC];
    logic [31:0] access_reg [N_DESC];
    logic [31:0] access_next [N_DESC];
    logic [31:0] word3_reg [N_DESC];
    logic [31:0] word3_next [N_DESC];

    // packed view handed to the macros
    bapc_pkg::bapc_desc_type desc [N_DESC];

    // per port error capture
    logic [31:0] ear_reg [N_PORT];
    logic [31:0] ear_next [N_PORT];
    logic [31:0] edr_reg [N_PORT];
    logic [31:0] edr_next [N_PORT];
    logic [N_PORT-1:0] slave_port_error_flags_reg;
    logic [N_PORT-1:0] slave_port_error_flags_next;
    logic [N_PORT-1:0] dma_reg;
    logic [N_PORT-1:0] dma_next;

    // evaluation results
    logic [N_DESC-1:0] not_allowed [N_PORT];
    logic [N_DESC-1:0] err_term [N_PORT];
    logic [N_PORT-1:0] deny;
    logic [N_PORT-1:0] fault;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        // one byte lane at a time
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // address of descriptor word w of descriptor n
    function automatic logic [11:0] desc_adr(input int n, input int w);
        return bapc_pkg::DESC_BASE + 12'(n * bapc_pkg::DESC_STRIDE + w * 4);
    endfunction : desc_adr

    // address of error address word of port p, detail follows it
    function automatic logic [11:0] err_adr(input int p);
        return bapc_pkg::ERR_BASE + 12'(p * bapc_pkg::ERR_STRIDE);
    endfunction : err_adr

    // classic single-cycle answer: ack one cycle after the request, then drop
    assign ack_next = WB_CYC_I & WB_STB_I & ~ack_reg;
    // read data latched as ack rises
    assign rd_strobe = ack_next & ~WB_WE_I;
    // a write lands on the edge where the master samples ack
    assign wr_strobe = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;

    // read data mux, unmapped addresses read as zero
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_strobe) begin
            rdata_next = 32'h0000_0000;
            // control word
            if (WB_ADR_I == bapc_pkg::CTRL_OFS) begin
                rdata_next[bapc_pkg::CTRL_EN_BIT] = en_reg;
                rdata_next[bapc_pkg::CTRL_SLAVE_PORT_ERROR_FLAGS_LSB +: N_PORT] = slave_port_error_flags_reg;
            end
            // error capture words
            for (int p = 0; p < N_PORT; p++) begin
                if (WB_ADR_I == err_adr(p)) begin
                    rdata_next = ear_reg[p];
                end
                if (WB_ADR_I == err_adr(p) + 12'h004) begin
                    rdata_next = edr_reg[p];
                end
            end
            // descriptor words
            for (int n = 0; n < N_DESC; n++) begin
                // start address
                if (WB_ADR_I == desc_adr(n, 0)) begin
                    rdata_next = start_reg[n];
                end

                // inclusive end address
                if (WB_ADR_I == desc_adr(n, 1)) begin
                    rdata_next = end_reg[n];
                end

                // access rights
                if (WB_ADR_I == desc_adr(n, 2)) begin
                    rdata_next = access_reg[n];
                end

                // valid, identifier and mask
                if (WB_ADR_I == desc_adr(n, 3)) begin
                    rdata_next = word3_reg[n];
                end

                // alternate view of access rights
                if (WB_ADR_I == bapc_pkg::AAC_BASE + 12'(n * bapc_pkg::AAC_STRIDE)) begin
                    rdata_next = access_reg[n];
                end
            end
        end
    end

    // control and descriptor writes
    always_comb begin
        logic [31:0] w3;
        w3 = 32'h0000_0000;
        en_next = en_reg;
        for (int n = 0; n < N_DESC; n++) begin
            start_next[n] = start_reg[n];
            end_next[n] = end_reg[n];
            access_next[n] = access_reg[n];
            word3_next[n] = word3_reg[n];
            if (wr_strobe) begin
                // start word, drops valid
                if (WB_ADR_I == desc_adr(n, 0)) begin
                    start_next[n] = merge(start_reg[n], WB_DAT_I, WB_SEL_I);
                    word3_next[n][bapc_pkg::VALID_BIT] = 1'b0;
                end

                // end word, drops valid
                if (WB_ADR_I == desc_adr(n, 1)) begin
                    end_next[n] = merge(end_reg[n], WB_DAT_I, WB_SEL_I);
                    word3_next[n][bapc_pkg::VALID_BIT] = 1'b0;
                end

                // access word, drops valid
                if (WB_ADR_I == desc_adr(n, 2)) begin
                    access_next[n] = merge(access_reg[n], WB_DAT_I, WB_SEL_I);
                    word3_next[n][bapc_pkg::VALID_BIT] = 1'b0;
                end

                if (WB_ADR_I == desc_adr(n, 3)) begin
                    // valid follows bit 31 of the merged word
                    w3 = merge(word3_reg[n], WB_DAT_I, WB_SEL_I);
                    word3_next[n] = w3;
                end

                if (WB_ADR_I == bapc_pkg::AAC_BASE + 12'(n * bapc_pkg::AAC_STRIDE)) begin
                    // same storage as word 2, valid left alone
                    access_next[n] = merge(access_reg[n], WB_DAT_I, WB_SEL_I);
                end
            end
        end
        // global enable, low byte lane
        if (wr_strobe && WB_ADR_I == bapc_pkg::CTRL_OFS && WB_SEL_I[0]) begin
            en_next = WB_DAT_I[bapc_pkg::CTRL_EN_BIT];
        end
    end

    // descriptor view for the evaluation matrix
    always_comb begin
        for (int n = 0; n < N_DESC; n++) begin
            desc[n].start_addr = start_reg[n];
            desc[n].end_addr = end_reg[n];
            desc[n].access = access_reg[n];
            // word 3 splits into identifier, mask and valid
            desc[n].pid = word3_reg[n][bapc_pkg::PID_LSB +: bapc_pkg::PID_W];
            desc[n].process_identifier_mask = word3_reg[n][bapc_pkg::MASK_LSB +: bapc_pkg::PID_W];
            desc[n].valid_flag = word3_reg[n][bapc_pkg::VALID_BIT];
        end
    end

    // one macro per descriptor and port, one gate per port
    for (genvar p = 0; p < N_PORT; p++) begin : g_port
        // evaluation macros of this port
        for (genvar n = 0; n < N_DESC; n++) begin : g_desc
            bapc_eval u_eval (
                .enable(en_reg),
                .desc(desc[n]),
                .req(M_REQ[p]),
                .not_allowed(not_allowed[p][n]),
                .err_term(err_term[p][n])
            );
        end

        // deny only when every macro says not allowed, and only when enabled
        assign deny[p] = en_reg & (&not_allowed[p]);

        // cancel and error response for this port
        bapc_gate u_gate (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .deny(deny[p]),
            .m_req(M_REQ[p]),
            .s_rsp(S_RSP[p]),
            .s_req(S_REQ[p]),
            .s_hready(S_HREADY[p]),
            .m_rsp(M_RSP[p]),
            .fault(fault[p])
        );
    end

    // fault capture; a new fault wins over a software clear
    always_comb begin
        logic [31:0] det;
        det = 32'h0000_0000;
        for (int p = 0; p < N_PORT; p++) begin
            ear_next[p] = ear_reg[p];
            edr_next[p] = edr_reg[p];
            slave_port_error_flags_next[p] = slave_port_error_flags_reg[p];
            dma_next[p] = dma_reg[p];
            // write one clears flag and interrupt
            if (wr_strobe && WB_ADR_I == bapc_pkg::CTRL_OFS &&
                WB_SEL_I[(bapc_pkg::CTRL_SLAVE_PORT_ERROR_FLAGS_LSB + p) / 8] &&
                WB_DAT_I[bapc_pkg::CTRL_SLAVE_PORT_ERROR_FLAGS_LSB + p]) begin
                slave_port_error_flags_next[p] = 1'b0;
                dma_next[p] = 1'b0;
            end

            // capture comes later, so it wins
            if (fault[p]) begin
                // access detail word
                det = 32'h0000_0000;
                det[bapc_pkg::EDR_ACD_LSB +: N_DESC] = err_term[p];
                det[bapc_pkg::EDR_MASTER_LSB +: bapc_pkg::MASTER_W] = M_REQ[p].hmaster;
                det[bapc_pkg::EDR_WRITE_BIT] = M_REQ[p].hwrite;
                det[bapc_pkg::EDR_SUP_BIT] = M_REQ[p].hprot[bapc_pkg::HPROT_PRIV_BIT];
                det[bapc_pkg::EDR_DATA_BIT] = M_REQ[p].hprot[bapc_pkg::HPROT_DATA_BIT];
                ear_next[p] = M_REQ[p].haddr;
                edr_next[p] = det;
                slave_port_error_flags_next[p] = 1'b1;
                if (DMA_MASTERS[M_REQ[p].hmaster]) begin
                    dma_next[p] = 1'b1;
                end
            end
        end
    end

    // register stage
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            en_reg <= bapc_pkg::CTRL_EN_RESET;
            slave_port_error_flags_reg <= '0;
            dma_reg <= '0;
            // descriptors zero and invalid
            for (int n = 0; n < N_DESC; n++) begin
                start_reg[n] <= 32'h0000_0000;
                end_reg[n] <= 32'h0000_0000;
                access_reg[n] <= bapc_pkg::ACCESS_RESET;
                word3_reg[n] <= 32'h0000_0000;
            end
            // empty captures
            for (int p = 0; p < N_PORT; p++) begin
                ear_reg[p] <= 32'h0000_0000;
                edr_reg[p] <= 32'h0000_0000;
            end
        end else begin
            // bus slave
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;

            // control and flags
            en_reg <= en_next;
            slave_port_error_flags_reg <= slave_port_error_flags_next;
            dma_reg <= dma_next;

            // descriptor storage
            start_reg <= start_next;
            end_reg <= end_next;
            access_reg <= access_next;
            word3_reg <= word3_next;

            // fault capture
            ear_reg <= ear_next;
            edr_reg <= edr_next;
        end
    end

    // Wishbone outputs straight from registers, the interrupt an OR over dma_reg
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;
    assign DMA_IRQ = |dma_reg;
endmodule : bapc_top

// ### testbench/bapc_top_asserts.sv
// checker on the ports of the protection checker top
`timescale 1ns/100ps
module bapc_top_asserts #(
    parameter int N_PORT = 2
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire bapc_pkg::bapc_ahb_req_type M_REQ [N_PORT],
    input wire bapc_pkg::bapc_ahb_rsp_type M_RSP [N_PORT],
    input wire bapc_pkg::bapc_ahb_req_type S_REQ [N_PORT],
    input wire logic S_HREADY [N_PORT],
    input wire bapc_pkg::bapc_ahb_rsp_type S_RSP [N_PORT],
    input wire logic DMA_IRQ
);
    logic deny0;
    logic deny1;
    // a taken address phase that the gate hides from the slave
    assign deny0 = M_RSP[0].hready && M_REQ[0].htrans[1] && !S_REQ[0].htrans[1];
    assign deny1 = M_RSP[1].hready && M_REQ[1].htrans[1] && !S_REQ[1].htrans[1];
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    // gate and register bus relations
    a_err_two_cycle: assert property (deny0 |=> M_RSP[0] == 2'h1 ##1 M_RSP[0] == 2'h3)
        else $error("denied transfer without two-cycle error");
    a_cancel_err: assert property (M_RSP[0] == 2'h1 |-> !S_REQ[0].htrans[1])
        else $error("slave sees transfer in first error cycle");
    a_ready_tie: assert property (S_HREADY[0] == M_RSP[0].hready)
        else $error("slave ready differs from master ready");
    a_fields_pass: assert property (S_REQ[0][47:0] == M_REQ[0][47:0])
        else $error("address phase fields altered");
    a_resp_relay: assert property (M_RSP[1].hready && S_REQ[1].htrans[1] |=>
        (M_RSP[1] == S_RSP[1]) [*3]) else $error("slave response not relayed");
    a_irq_cause: assert property ($rose(DMA_IRQ) |-> $past(deny0 || deny1))
        else $error("interrupt without a denied transfer");
    a_quiet_reset: assert property ($fell(SYS_RST) |-> !DMA_IRQ && !WB_ACK_O)
        else $error("outputs active after reset");
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("register access not acknowledged");
    c_deny: cover property (deny0);
    c_slow_pass: cover property (!S_RSP[1].hready);
    c_irq: cover property ($rose(DMA_IRQ));
endmodule : bapc_top_asserts

bind bapc_top bapc_top_asserts #(.N_PORT(N_PORT)) bapc_top_asserts_i (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .M_REQ(M_REQ), .M_RSP(M_RSP), .S_REQ(S_REQ),
    .S_HREADY(S_HREADY), .S_RSP(S_RSP), .DMA_IRQ(DMA_IRQ)
);

// ### testbench/bapc_slave_model.sv
// behavioural slave on a monitored port with fixed wait states
`timescale 1ns/100ps
module bapc_slave_model #(
    parameter int WAIT = 0
) (
    input wire logic clk,
    input wire logic rst,
    input wire bapc_pkg::bapc_ahb_req_type s_req,
    input wire logic s_hready,
    output bapc_pkg::bapc_ahb_rsp_type s_rsp,
    output logic [7:0] seen_cnt
);
    int busy;
    // counts transfers it saw and stretches each data phase
    always @(posedge clk) begin
        if (rst) begin
            seen_cnt <= 8'h0;
            busy <= 0;
        end else if (s_hready && s_req.htrans[1]) begin
            seen_cnt <= seen_cnt + 8'h1;
            busy <= WAIT;
        end else if (busy > 0) begin
            busy <= busy - 1;
        end
    end
    assign s_rsp = '{busy == 0, 1'h0};
endmodule : bapc_slave_model

// ### testbench/bapc_top_bench.sv
// self-checking bench for the protection checker
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
`define WAIT(c) n = 0; \
    do begin @(posedge SYS_CLK); n++; end while ((c) !== 1'h1 && n < 16); \
    if (n >= 16) begin error_cnt++; give_verdict(); end
module bapc_top_bench;
    logic SYS_CLK = 1'h0;
    logic SYS_RST = 1'h1;
    logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack, dma_irq;
    logic [3:0] wb_sel = 4'hf;
    logic [11:0] wb_adr = 12'h0;
    logic [31:0] wb_dat = 32'h0, wb_rdata, rd_data;
    bapc_pkg::bapc_ahb_req_type m_req [2], s_req [2];
    bapc_pkg::bapc_ahb_rsp_type m_rsp [2], s_rsp [2];
    logic s_hready [2];
    logic [7:0] seen [2];
    int error_cnt = 0, check_count = 0;
    bapc_top #(.N_DESC(4), .N_PORT(2)) bapc_top_i (
        .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
        .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat),
        .WB_DAT_O(wb_rdata), .WB_ACK_O(wb_ack), .M_REQ(m_req), .M_RSP(m_rsp),
        .S_REQ(s_req), .S_HREADY(s_hready), .S_RSP(s_rsp), .DMA_IRQ(dma_irq)
    );
    // port 0 slave answers at once, port 1 after two waits
    for (genvar p = 0; p < 2; p++) begin : g_port
        bapc_slave_model #(.WAIT(2 * p)) bapc_slave_model_i (
            .clk(SYS_CLK), .rst(SYS_RST), .s_req(s_req[p]), .s_hready(s_hready[p]),
            .s_rsp(s_rsp[p]), .seen_cnt(seen[p])
        );
    end
    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic give_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // one classic register cycle
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int n;
        @(posedge SYS_CLK);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        `WAIT(wb_ack)
        rd_data = wb_rdata;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
    endtask : wb
    // loads a descriptor, valid word last
    task automatic desc(input int d, input logic [31:0] s, e, acc, w3);
        logic [11:0] b;
        b = bapc_pkg::DESC_BASE + 12'(16 * d);
        wb(1'h1, b, s);
        wb(1'h1, b + 12'h4, e);
        wb(1'h1, b + 12'h8, acc);
        wb(1'h1, b + 12'hc, w3);
    endtask : desc
    // one transfer; att is write, supervisor, data
    task automatic ahb(input int p, input logic [31:0] a, input logic [2:0] att,
                       input logic [2:0] m, input logic [7:0] pid, input logic err);
        int n;
        logic [7:0] seen0;
        logic [3:0] en;
        seen0 = seen[p];
        en = err ? 4'h2 : 4'(1 + 2 * p);
        @(posedge SYS_CLK);
        m_req[p] <= '{2'h2, a, att[2], {2'h0, att[1:0]}, m, pid};
        `WAIT(m_rsp[p].hready)
        `CHK(s_req[p].htrans, err ? 2'h0 : 2'h2)
        m_req[p].htrans <= 2'h0;
        `WAIT(m_rsp[p].hready)
        `CHK({m_rsp[p].hresp, n[3:0], seen[p] - seen0}, {err, en, 8'(!err)})
    endtask : ahb
    // main sequence
    initial begin
        m_req[0] = '0;
        m_req[1] = '0;
        repeat (3) @(posedge SYS_CLK);
        SYS_RST <= 1'h0;
        wb(1'h0, 12'h000, 32'h0);
        `CHK(rd_data, 32'h0)
        wb(1'h0, 12'h300, 32'h0);
        `CHK(rd_data, 32'h0)
        ahb(0, 32'h9000, 3'h1, 3'h0, 8'h0, 1'h0);
        desc(0, 32'h1000, 32'h1fff, 32'h0100_001c, 32'h8000_0000);
        desc(1, 32'h1000, 32'h10ff, 32'h0000_001e, 32'h8000_0000);
        desc(2, 32'h5000, 32'h4000, 32'h0000_001f, 32'h8000_0000);
        desc(3, 32'h8000, 32'h8fff, 32'h0000_0fc0, 32'h8000_5af0);
        wb(1'h1, 12'h000, 32'h1);
        ahb(0, 32'h1000, 3'h1, 3'h0, 8'h0, 1'h0);
        ahb(1, 32'h1fff, 3'h1, 3'h0, 8'h0, 1'h0);
        ahb(0, 32'h2000, 3'h1, 3'h0, 8'h0, 1'h1);
        ahb(1, 32'h0fff, 3'h1, 3'h0, 8'h0, 1'h1);
        ahb(0, 32'h1100, 3'h5, 3'h0, 8'h0, 1'h1);
        ahb(0, 32'h1100, 3'h0, 3'h0, 8'h0, 1'h1);
        ahb(0, 32'h1000, 3'h5, 3'h0, 8'h0, 1'h0);
        ahb(0, 32'h4800, 3'h1, 3'h0, 8'h0, 1'h1);
        ahb(1, 32'h1000, 3'h5, 3'h4, 8'h0, 1'h0);
        ahb(1, 32'h1000, 3'h1, 3'h4, 8'h0, 1'h1);
        wb(1'h0, 12'h018, 32'h0);
        `CHK(rd_data, 32'h1000)
        wb(1'h0, 12'h01c, 32'h0);
        `CHK(rd_data, 32'h0003_0041)
        wb(1'h0, 12'h000, 32'h0);
        `CHK({rd_data, dma_irq}, {32'h301, 1'h0})
        // each supervisor encoding, changed through the alternate word
        for (int s = 0; s < 4; s++) begin
            wb(1'h1, 12'h800, 32'h0100_0004 | 32'(s << 3));
            ahb(0, 32'h1800, 3'h7, 3'h0, 8'h0, s[0]);
            ahb(0, 32'h1800, 3'h2, 3'h0, 8'h0, s[1]);
        end
        wb(1'h0, 12'h40c, 32'h0);
        `CHK(rd_data, 32'h8000_0000)
        ahb(0, 32'h8000, 3'h1, 3'h1, 8'h53, 1'h0);
        ahb(0, 32'h8000, 3'h1, 3'h1, 8'h4a, 1'h1);
        `CHK(dma_irq, 1'h1)
        wb(1'h1, 12'h000, 32'h0000_0301);
        repeat (2) @(posedge SYS_CLK);
        `CHK(dma_irq, 1'h0)
        wb(1'h1, 12'h80c, 32'h0000_07c0);
        ahb(0, 32'h8000, 3'h1, 3'h1, 8'h4a, 1'h0);
        wb(1'h1, 12'h430, 32'h8000);
        ahb(0, 32'h8000, 3'h1, 3'h1, 8'h4a, 1'h1);
        wb_sel <= 4'h8;
        wb(1'h1, 12'h43c, 32'h8000_0000);
        wb_sel <= 4'hf;
        ahb(0, 32'h8000, 3'h1, 3'h1, 8'h4a, 1'h0);
        wb(1'h1, 12'h41c, 32'h0);
        ahb(0, 32'h1000, 3'h5, 3'h0, 8'h0, 1'h1);
        wb(1'h1, 12'h000, 32'h0);
        ahb(1, 32'h2000, 3'h5, 3'h0, 8'h0, 1'h0);
        give_verdict();
    end
endmodule : bapc_top_bench
